// *** hdl/cpu_pkg.sv ***
// Purpose: Constants for the compare and PWM unit (compare_value_register, timers, bus map)
// Assumes: One 100 MHz clock, Avalon-MM register slave with 32-bit words
// Notes: Offsets are byte addresses, one register per aligned word
package cpu_pkg;
    localparam logic [3:0] ADDR_CTRL = 4'h0;   // unit_control_register
    localparam logic [3:0] ADDR_CMPV = 4'h4;   // compare_value_register
    localparam logic [3:0] ADDR_T1 = 4'h8;     // first_timer_count and its control
    localparam logic [3:0] ADDR_T2 = 4'hC;     // period timer count, limit, control
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_OUT_BIT = 5;
    localparam int CTRL_FMT_BIT = 4;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] PLIM_RST = 8'hFF;
    localparam logic [15:0] CMPV_RST = 16'h0000;
    localparam logic [3:0] MODE_OFF = 4'b0000;
    localparam logic [3:0] MODE_TGL_CLR = 4'b0001;
    localparam logic [3:0] MODE_TGL = 4'b0010;
    localparam logic [3:0] MODE_SET = 4'b1000;
    localparam logic [3:0] MODE_CLR = 4'b1001;
    localparam logic [3:0] MODE_PLS = 4'b1010;
    localparam logic [3:0] MODE_PLS_CLR = 4'b1011;
    localparam int OSC_PHASES = 4;    // Oscillator periods per instruction clock
    typedef enum logic [1:0] {
        CPU_BUS_IDLE = 2'b00,
        CPU_BUS_ACK = 2'b01
    } cpu_bus_t;
endpackage : cpu_pkg

// *** hdl/cpu_unit.sv ***
// Purpose: Compare and standard PWM unit with its own timers and Avalon-MM registers
// Assumes: clk_sys_i is the oscillator clock; instruction clock is one in four cycles
// Notes: Capture modes (0011..0111) raise no events here and leave the output latch holding its value
`timescale 1ns/1ps
`default_nettype none
module cpu_unit (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic sleep_i,
    input wire logic ext_tick_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic unit_pin_o,
    output logic unit_pin_oe_o,
    output logic unit_out_int_o,
    output logic unit_event_flag_o,
    output logic period_timer_flag_o,
    output logic wake_o
);
    // Software state
    logic [7:0] ctrl_r;
    logic [15:0] cmpv_r;
    logic [15:0] t1_r;
    logic t1_on_r;
    logic t1_ext_r;
    logic [7:0] t2_r;
    logic [7:0] plim_r;
    logic [7:0] t2ctl_r;
    logic pin_dir_in_r;
    logic ie_r;
    logic [1:0] phase_r;
    logic [3:0] pre_r;
    logic [9:0] duty_buf_r;
    logic out_r;
    logic pulse_r;
    logic evf_r;
    logic t2f_r;
    logic [3:0] post_r;
    logic per_dly_r;
    cpu_pkg::cpu_bus_t bus_st_r;
    logic [31:0] rdata_nxt;

    wire logic [3:0] mode = ctrl_r[3:0];
    wire logic en = ctrl_r[cpu_pkg::CTRL_EN_BIT];
    wire logic pwm_mode = en && (mode[3:2] == 2'b11);
    wire logic wr_go = avs_write_i && (bus_st_r == cpu_pkg::CPU_BUS_IDLE);

    // Compare modes are the 10xx codes plus 0001 and 0010
    function automatic logic is_cmp(input logic [3:0] m);
        is_cmp = (m[3:2] == 2'b10) || (m == cpu_pkg::MODE_TGL_CLR) || (m == cpu_pkg::MODE_TGL);
    endfunction : is_cmp

    // Prescale divide count from the 3-bit select, capped at 1:16
    function automatic logic [3:0] pre_max(input logic [2:0] ck);
        unique case (ck)
            3'd0: pre_max = 4'h0;
            3'd1: pre_max = 4'h1;
            3'd2: pre_max = 4'h3;
            default: pre_max = 4'hF;
        endcase
    endfunction : pre_max

    wire logic cmp_mode = en && is_cmp(mode);
    wire logic inst_tick = (phase_r == 2'b11) && !sleep_i;   // Oscillator halts in sleep
    // First timer tick: instruction clock, or external tick that keeps running in sleep
    wire logic t1_tick = t1_on_r && (t1_ext_r ? ext_tick_i : inst_tick);
    wire logic cmp_hit = cmp_mode && (cmpv_r == t1_r);
    wire logic match = cmp_hit && t1_tick;   // One event per timer value
    wire logic t2_on = t2ctl_r[7];
    wire logic t2_tick = t2_on && inst_tick && (pre_r == pre_max(t2ctl_r[6:4]));
    wire logic per_match = t2_tick && (t2_r == plim_r);
    // Low time-base bits step four times per period timer step so one step is prescale oscillator cycles
    wire logic [1:0] low2 = (t2ctl_r[6:4] == 3'd0) ? phase_r :
        (t2ctl_r[6:4] == 3'd1) ? {pre_r[0], phase_r[1]} :
        (t2ctl_r[6:4] == 3'd2) ? pre_r[1:0] : pre_r[3:2];
    wire logic [9:0] tbase = {t2_r, low2};
    wire logic [9:0] duty_in = ctrl_r[cpu_pkg::CTRL_FMT_BIT] ?
        {cmpv_r[15:8], cmpv_r[7:6]} : {cmpv_r[9:8], cmpv_r[7:0]};

    // Oscillator phase divider, frozen in sleep
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            phase_r <= 2'b00;
        else if (!sleep_i)
            phase_r <= phase_r + 2'b01;
    end

    // Single-cycle Avalon answer: one wait cycle then ack
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            bus_st_r <= cpu_pkg::CPU_BUS_IDLE;
        else if (bus_st_r == cpu_pkg::CPU_BUS_ACK)
            bus_st_r <= cpu_pkg::CPU_BUS_IDLE;
        else if (avs_read_i || avs_write_i)
            bus_st_r <= cpu_pkg::CPU_BUS_ACK;
    end

    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        unique case (avs_address_i)
            cpu_pkg::ADDR_CTRL: rdata_nxt = {22'h0, ie_r, pin_dir_in_r,
                ctrl_r[7], 1'b0, out_r, ctrl_r[4:0]};
            cpu_pkg::ADDR_CMPV: rdata_nxt = {16'h0000, cmpv_r};
            cpu_pkg::ADDR_T1: rdata_nxt = {13'h0, evf_r, t1_ext_r, t1_on_r, t1_r};
            cpu_pkg::ADDR_T2: rdata_nxt = {7'h0, t2f_r, t2ctl_r, plim_r, t2_r};
            default: rdata_nxt = 32'h0000_0000;   // Unmapped reads return zero
        endcase
    end

    // Read data and waitrequest registered; waitrequest low only in the ack cycle
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            avs_readdata_o <= 32'h0000_0000;
            avs_waitrequest_o <= 1'b1;
        end
        else
        begin
            avs_readdata_o <= rdata_nxt;
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) &&
                (bus_st_r == cpu_pkg::CPU_BUS_IDLE));
        end
    end

    // Control register, pin direction and event enable; reset sets pin to input
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_r <= cpu_pkg::CTRL_RST;
            pin_dir_in_r <= 1'b1;
            ie_r <= 1'b0;
        end
        else if (wr_go && avs_address_i == cpu_pkg::ADDR_CTRL)
        begin
            if (avs_byteenable_i[0])
                ctrl_r <= {avs_writedata_i[7], 2'b00, avs_writedata_i[4:0]};
            if (avs_byteenable_i[1])
            begin
                pin_dir_in_r <= avs_writedata_i[8];
                ie_r <= avs_writedata_i[9];
            end
        end
    end

    // Compare value register, byte-wise; duty written at any time
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            cmpv_r <= cpu_pkg::CMPV_RST;
        else if (wr_go && avs_address_i == cpu_pkg::ADDR_CMPV)
        begin
            if (avs_byteenable_i[0])
                cmpv_r[7:0] <= avs_writedata_i[7:0];
            if (avs_byteenable_i[1])
                cmpv_r[15:8] <= avs_writedata_i[15:8];
        end
    end

    // First timer; a clearing compare mode wins over counting
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            t1_r <= 16'h0000;
            t1_on_r <= 1'b0;
            t1_ext_r <= 1'b0;
        end
        else if (wr_go && avs_address_i == cpu_pkg::ADDR_T1)
        begin
            if (avs_byteenable_i[0])
                t1_r[7:0] <= avs_writedata_i[7:0];
            if (avs_byteenable_i[1])
                t1_r[15:8] <= avs_writedata_i[15:8];
            if (avs_byteenable_i[2])
            begin
                t1_on_r <= avs_writedata_i[16];
                t1_ext_r <= avs_writedata_i[17];
            end
        end
        else if (match && (mode == cpu_pkg::MODE_TGL_CLR || mode == cpu_pkg::MODE_PLS_CLR))
            t1_r <= 16'h0000;
        else if (t1_tick)
            t1_r <= t1_r + 16'h0001;
    end

    // Event flag: set wins over a software clear (write 1 to bit 18)
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            evf_r <= 1'b0;
        else if (match || per_match && pwm_mode)
            evf_r <= 1'b1;
        else if (wr_go && avs_address_i == cpu_pkg::ADDR_T1 && avs_byteenable_i[2]
            && avs_writedata_i[18])
            evf_r <= 1'b0;
    end

    // Period timer, limit, control, prescaler and postscaled flag
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            t2_r <= 8'h00;
            plim_r <= cpu_pkg::PLIM_RST;
            t2ctl_r <= 8'h00;
            pre_r <= 4'h0;
            post_r <= 4'h0;
            t2f_r <= 1'b0;
        end
        else
        begin
            if (t2_on && inst_tick)
                pre_r <= (pre_r == pre_max(t2ctl_r[6:4])) ? 4'h0 : pre_r + 4'h1;
            if (per_match)
            begin
                t2_r <= 8'h00;
                post_r <= (post_r == t2ctl_r[3:0]) ? 4'h0 : post_r + 4'h1;
            end
            else if (t2_tick)
                t2_r <= t2_r + 8'h01;
            // Postscaler only paces the flag; PWM ignores it
            if (per_match && post_r == t2ctl_r[3:0])
                t2f_r <= 1'b1;
            else if (wr_go && avs_address_i == cpu_pkg::ADDR_T2 && avs_byteenable_i[3]
                && avs_writedata_i[24])
                t2f_r <= 1'b0;
            if (wr_go && avs_address_i == cpu_pkg::ADDR_T2)
            begin
                if (avs_byteenable_i[0])
                    t2_r <= avs_writedata_i[7:0];
                if (avs_byteenable_i[1])
                    plim_r <= avs_writedata_i[15:8];
                if (avs_byteenable_i[2])
                begin
                    t2ctl_r <= avs_writedata_i[23:16];
                    pre_r <= 4'h0;
                end
            end
        end
    end

    // Duty buffer loads only at period end, giving glitchless double buffering
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            duty_buf_r <= 10'h000;
        else if (per_match)
            duty_buf_r <= duty_in;
    end

    // Wrap delayed by one cycle; the registered clear lags its step by one cycle as well
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            per_dly_r <= 1'b0;
        else
            per_dly_r <= per_match;
    end

    // Output latch: compare actions and PWM set/clear
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            out_r <= 1'b0;
            pulse_r <= 1'b0;
        end
        else if (wr_go && avs_address_i == cpu_pkg::ADDR_CTRL && avs_byteenable_i[0]
            && avs_writedata_i[7:0] == 8'h00)
        begin
            out_r <= 1'b0;
            pulse_r <= 1'b0;
        end
        else if (!en || mode == cpu_pkg::MODE_OFF)
        begin
            out_r <= 1'b0;
            pulse_r <= 1'b0;
        end
        else if (pwm_mode)
        begin
            // Both edges shifted one cycle, so the high time is duty times prescale
            if (per_dly_r && duty_buf_r != 10'h000)
                out_r <= 1'b1;
            else if (t2_on && !sleep_i && tbase == duty_buf_r)
                out_r <= 1'b0;
        end
        else if (match)
        begin
            unique case (mode)
                cpu_pkg::MODE_TGL_CLR, cpu_pkg::MODE_TGL: out_r <= !out_r;
                cpu_pkg::MODE_SET: out_r <= 1'b1;
                cpu_pkg::MODE_CLR: out_r <= 1'b0;
                default:
                begin
                    out_r <= 1'b1;
                    pulse_r <= 1'b1;
                end
            endcase
        end
        else if (pulse_r && t1_tick)
        begin
            out_r <= 1'b0;
            pulse_r <= 1'b0;
        end
    end

    // Pin, internal copy and wake are registered
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            unit_pin_o <= 1'b0;
            unit_pin_oe_o <= 1'b0;
            unit_out_int_o <= 1'b0;
            unit_event_flag_o <= 1'b0;
            period_timer_flag_o <= 1'b0;
            wake_o <= 1'b0;
        end
        else
        begin
            unit_pin_o <= out_r;
            unit_pin_oe_o <= !pin_dir_in_r;
            unit_out_int_o <= out_r;
            unit_event_flag_o <= evf_r;
            period_timer_flag_o <= t2f_r;
            wake_o <= evf_r && ie_r;
        end
    end

    property p_tclr;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (match && mode == cpu_pkg::MODE_TGL_CLR && !wr_go) |=> (t1_r == 16'h0000);
    endproperty
    a_tclr: assert property (p_tclr) else $error("timer not cleared");
    property p_evf;
        @(posedge clk_sys_i) disable iff (!rst_n_i) match |=> evf_r ##1 unit_event_flag_o;
    endproperty
    a_evf: assert property (p_evf) else $error("event flag missing");
    property p_tgl;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (match && mode == cpu_pkg::MODE_TGL && !wr_go) |=> (out_r != $past(out_r));
    endproperty
    a_tgl: assert property (p_tgl) else $error("no toggle");
    property p_zero;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (wr_go && avs_address_i == cpu_pkg::ADDR_CTRL && avs_byteenable_i[0]
            && avs_writedata_i[7:0] == 8'h00) |=> !out_r ##1 !unit_pin_o;
    endproperty
    a_zero: assert property (p_zero) else $error("zero write kept output");
    property p_int;
        @(posedge clk_sys_i) disable iff (!rst_n_i) ##1 (unit_out_int_o == $past(out_r));
    endproperty
    a_int: assert property (p_int) else $error("internal copy wrong");
    property p_buf;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !per_match |=> (duty_buf_r == $past(duty_buf_r));
    endproperty
    a_buf: assert property (p_buf) else $error("duty buffer changed early");
    property p_per;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (per_match && pwm_mode && duty_in != 10'h000 && !wr_go) ##1 (pwm_mode && !wr_go)
            |=> out_r;
    endproperty
    a_per: assert property (p_per) else $error("pin not set at period");
    property p_sleep;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (sleep_i && !wr_go) |=> (t2_r == $past(t2_r));
    endproperty
    a_sleep: assert property (p_sleep) else $error("period timer moved in sleep");
    property p_pulse;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (match && mode == cpu_pkg::MODE_PLS && !wr_go) |=> out_r;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse not raised");
    c_match: cover property (@(posedge clk_sys_i) match);
    c_per: cover property (@(posedge clk_sys_i) per_match && pwm_mode);
    c_pclr: cover property (@(posedge clk_sys_i) pwm_mode && out_r ##1 !out_r);
endmodule : cpu_unit
`default_nettype wire

// *** testbench/cpu_unit_tb.sv ***
// Purpose: Self-checking bench for the compare and PWM unit over its Avalon-MM slave
// Assumes: First-timer ticks come from ext_tick_i so compare matches are fully controlled
// Notes: PWM widths are counted in clk_sys_i cycles at the pin
`timescale 1ns/1ps
`default_nettype none
module cpu_unit_tb;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sleep_i = 1'b0;
    logic ext_tick_i = 1'b0;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic unit_pin_o;
    logic unit_pin_oe_o;
    logic unit_out_int_o;
    logic unit_event_flag_o;
    logic period_timer_flag_o;
    logic wake_o;
    logic [31:0] rd_data;
    logic [31:0] rd_prev;
    logic saw_high;
    int num_errors = 0;
    int num_checks = 0;
    logic [3:0] modes [6] = '{cpu_pkg::MODE_SET, cpu_pkg::MODE_CLR, cpu_pkg::MODE_TGL,
        cpu_pkg::MODE_PLS, cpu_pkg::MODE_TGL_CLR, cpu_pkg::MODE_PLS_CLR};
    int exp_pin [6] = '{1, 0, 1, 0, 0, 1};   // Clear modes match twice: toggle returns, pulse re-rises

    // 100 MHz system clock
    always #5 clk_sys_i = ~clk_sys_i;

    cpu_unit cpu_unit_i (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sleep_i(sleep_i), .ext_tick_i(ext_tick_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .unit_pin_o(unit_pin_o), .unit_pin_oe_o(unit_pin_oe_o), .unit_out_int_o(unit_out_int_o),
        .unit_event_flag_o(unit_event_flag_o), .period_timer_flag_o(period_timer_flag_o),
        .wake_o(wake_o)
    );

    task automatic give_verdict;
        begin
            $display("checks %0d errors %0d", num_checks, num_errors);
            if (num_errors == 0 && num_checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask : give_verdict

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        begin
            num_checks++;
            if (got !== exp)
            begin
                num_errors++;
                $display("unexpected %s: expected %h seen %h", what, exp, got);
            end
        end
    endtask : chk

    // One Avalon-MM transfer; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        begin
            avs_address_i <= a;
            avs_writedata_i <= wd;
            avs_write_i <= wr;
            avs_read_i <= ~wr;
            n = 0;
            do
            begin
                @(posedge clk_sys_i);
                n++;
            end
            while (avs_waitrequest_o !== 1'b0 && n < 50);
            rd_data = avs_readdata_o;
            avs_write_i <= 1'b0;
            avs_read_i <= 1'b0;
            if (n >= 50)
            begin
                chk("bus timeout", 32'h0000_0000, 32'h0000_0001);
                give_verdict();
            end
            else
                @(posedge clk_sys_i);
        end
    endtask : bus

    task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
        begin
            bus(1'b0, a, 32'h0000_0000);
            chk(what, exp, rd_data);
        end
    endtask : rd_chk

    // Single-cycle external tick, then a few cycles watching the internal output
    task automatic tick(input int cnt);
        begin
            repeat (cnt)
            begin
                ext_tick_i <= 1'b1;
                @(posedge clk_sys_i);
                ext_tick_i <= 1'b0;
                repeat (4)
                begin
                    @(posedge clk_sys_i);
                    if (unit_out_int_o === 1'b1)
                        saw_high = 1'b1;
                end
            end
        end
    endtask : tick

    // Level must stay put for n cycles; one compare for the whole stretch
    task automatic hold_chk(input string what, input logic exp, input int n);
        logic bad;
        begin
            bad = 1'b0;
            repeat (n)
            begin
                @(posedge clk_sys_i);
                if (unit_pin_o !== exp)
                    bad = 1'b1;
            end
            chk(what, 32'h0000_0000, {31'h0, bad});
        end
    endtask : hold_chk

    // Rise-to-rise measurement; bounded so a dead pin cannot hang the run
    task automatic measure(input bit do_chk, input int ehi, input int eper);
        int hi;
        int per;
        int n;
        begin
            n = 0;
            hi = 0;
            per = 0;
            while (unit_pin_o !== 1'b0 && n < 300)
            begin
                @(posedge clk_sys_i);
                n++;
            end
            while (unit_pin_o !== 1'b1 && n < 300)
            begin
                @(posedge clk_sys_i);
                n++;
            end
            while (unit_pin_o === 1'b1 && per < 300)
            begin
                @(posedge clk_sys_i);
                hi++;
                per++;
            end
            while (unit_pin_o !== 1'b1 && per < 300)
            begin
                @(posedge clk_sys_i);
                per++;
            end
            if (do_chk)
            begin
                chk("pwm high cycles", ehi, hi);
                chk("pwm period cycles", eper, per);
            end
        end
    endtask : measure

    task automatic pwm_pair(input int ehi, input int eper);
        begin
            measure(1'b0, 0, 0);
            measure(1'b1, ehi, eper);
        end
    endtask : pwm_pair

    initial
    begin
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        // Reset state of registers and pin direction
        rd_chk("ctrl reset", cpu_pkg::ADDR_CTRL, 32'h0000_0100);
        rd_chk("cmpv reset", cpu_pkg::ADDR_CMPV, 32'h0000_0000);
        rd_chk("t1 reset", cpu_pkg::ADDR_T1, 32'h0000_0000);
        rd_chk("t2 reset", cpu_pkg::ADDR_T2, 32'h0000_FF00);
        chk("pin oe reset", 32'h0, {31'h0, unit_pin_oe_o});
        rd_chk("unmapped read", 4'h2, 32'h0000_0000);
        // Compare modes: same value, same tick count, action per mode
        bus(1'b1, cpu_pkg::ADDR_CMPV, 32'h0000_0002);
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b1, cpu_pkg::ADDR_T1, 32'h0007_0000);
            chk("flag cleared", 32'h0, {31'h0, unit_event_flag_o});
            bus(1'b1, cpu_pkg::ADDR_CTRL, {24'h0, 4'h8, modes[i]});
            if (i == 3)
            begin
                chk("ctrl zero out", 32'h0, {31'h0, unit_out_int_o});
            end
            saw_high = 1'b0;
            tick(6);
            bus(1'b0, cpu_pkg::ADDR_T1, 32'h0000_0000);
            chk("event flag", 32'h1, {31'h0, unit_event_flag_o});
            chk("event flag reg", 32'h1, {31'h0, rd_data[18]});
            if (i < 4)
                chk("t1 runs on", 32'h6, {16'h0, rd_data[15:0]});
            else
                chk("t1 cleared", 32'h0, {16'h0, rd_data[15:0]});
            chk("compare pin", exp_pin[i], {31'h0, unit_pin_o});
            chk("internal copy", {31'h0, unit_pin_o}, {31'h0, unit_out_int_o});
            chk("pin driven", 32'h1, {31'h0, unit_pin_oe_o});
            if (i == 3 || i == 5)
                chk("pulse seen", 32'h1, {31'h0, saw_high});
            if (i == 2)
                bus(1'b1, cpu_pkg::ADDR_CTRL, 32'h0000_0000);
        end
        bus(1'b1, cpu_pkg::ADDR_CTRL, 32'h0000_028B);
        @(posedge clk_sys_i);
        chk("wake", 32'h1, {31'h0, wake_o});
        // Standard PWM, limit 3, right aligned duty 6
        bus(1'b1, cpu_pkg::ADDR_CMPV, 32'h0000_0006);
        bus(1'b1, cpu_pkg::ADDR_CTRL, 32'h0000_018C);
        bus(1'b1, cpu_pkg::ADDR_T2, 32'h0080_0300);
        pwm_pair(6, 16);
        chk("period flag", 32'h1, {31'h0, period_timer_flag_o});
        // Driver enabled only once the period flag has been seen
        bus(1'b1, cpu_pkg::ADDR_CTRL, 32'h0000_008C);
        chk("pwm pin driven", 32'h1, {31'h0, unit_pin_oe_o});
        bus(1'b1, cpu_pkg::ADDR_T2, 32'h0090_0300);
        pwm_pair(12, 32);
        bus(1'b1, cpu_pkg::ADDR_T2, 32'h009F_0300);
        pwm_pair(12, 32);
        // Left aligned duty 10 with prescale two
        bus(1'b1, cpu_pkg::ADDR_CTRL, 32'h0000_009C);
        bus(1'b1, cpu_pkg::ADDR_CMPV, 32'h0000_0280);
        pwm_pair(20, 32);
        // Zero duty never sets the pin; oversize duty never clears it
        bus(1'b1, cpu_pkg::ADDR_CMPV, 32'h0000_0000);
        repeat (80) @(posedge clk_sys_i);
        hold_chk("zero duty", 1'b0, 80);
        bus(1'b1, cpu_pkg::ADDR_CTRL, 32'h0000_008C);
        bus(1'b1, cpu_pkg::ADDR_CMPV, 32'h0000_0030);
        repeat (80) @(posedge clk_sys_i);
        hold_chk("oversize duty", 1'b1, 80);
        // Sleep freezes timer and pin
        sleep_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        bus(1'b0, cpu_pkg::ADDR_T2, 32'h0000_0000);
        rd_prev = rd_data;
        hold_chk("sleep pin", 1'b1, 40);
        rd_chk("sleep t2", cpu_pkg::ADDR_T2, rd_prev);
        sleep_i <= 1'b0;
        bus(1'b1, cpu_pkg::ADDR_CMPV, 32'h0000_0006);
        pwm_pair(12, 32);
        give_verdict();
    end

    // Bench-level guard against a hang anywhere
    initial
    begin
        repeat (50000) @(posedge clk_sys_i);
        chk("run timeout", 32'h0000_0000, 32'h0000_0001);
        give_verdict();
    end
endmodule : cpu_unit_tb
`default_nettype wire
